/* File: hw/dbgst_cfg.svh */
/*
 * Offsets, bit positions and reset values for the debug status block.
 * Assumes a 32-bit APB with word-aligned registers.
 */
`ifndef DBGST_CFG_SVH
`define DBGST_CFG_SVH
// Register byte offsets
`define DBGST_OFS_CTRL    12'h000
`define DBGST_OFS_STATUS  12'h004
`define DBGST_OFS_IRQ_ST  12'h008
`define DBGST_OFS_IRQ_MSK 12'h00C
// Field positions
`define DBGST_BIT_IDLE    7
`define DBGST_BIT_HALT    6
`define DBGST_BIT_RPROT   5
`define DBGST_BIT_MODE    7
// Reset values
`define DBGST_CTRL_RST    8'h00
`define DBGST_MSK_RST     3'h0
`endif

/* File: hw/dbgst_pkg.sv */
/*
 * Types shared by the debug status block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none
package dbgst_pkg;
    // APB access phase of the slave
    typedef enum logic [0:0] {
        DBGST_IDLE_PH,
        DBGST_ACC_PH
    } dbgst_phase_t;
    // Interrupt event bits: idle rise, halt entry, breakpoint hit
    typedef logic [2:0] dbgst_irq_t;
endpackage
`default_nettype wire

/* File: hw/dbgst_sync.sv */
/*
 * Two-flop synchroniser vector for asynchronous status inputs.
 * Assumes inputs are quasi-static levels.
 */
`timescale 1ns/1ps
`default_nettype none
module dbgst_sync (
    // Clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // Asynchronous levels in, synchronised out
    input  wire logic [2:0] async_in,
    output var  logic [2:0] sync_out
);
    logic [2:0] meta_r;  // First stage, read only by second
    logic [2:0] meta_nxt;
    logic [2:0] sync_nxt;

    //////////////////////////////////////////////////////////////////////
    // Next values
    always_comb begin
        meta_nxt = async_in;
        sync_nxt = meta_r;
    end

    // Registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_r   <= 3'h0;
            sync_out <= 3'h0;
        end else begin
            meta_r   <= meta_nxt;
            sync_out <= sync_nxt;
        end
    end
endmodule
`default_nettype wire

/* File: hw/dbgst_top.sv */
/*
 * Debug status register with the debug control mode bit, APB slave,
 * and a sticky interrupt on status events.
 * Assumes halt, breakpoint and read-protect option come from pins
 * outside the pclk domain; breakpoint is a level held at least
 * three pclk cycles per occurrence.
 * The status register has no write path; only control, interrupt
 * status and mask take writes.
 * Protection makes only the mode bit sticky; other control bits stay writable.
 */
// Decided for this implementation: the APB slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "dbgst_cfg.svh"
module dbgst_top (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output var  logic [31:0] prdata,
    output var  logic        pready,
    output var  logic        pslverr,
    // Device status pins
    input  wire logic        halt_state,
    input  wire logic        breakpoint_instruction,
    input  wire logic        read_protect_option,
    // Debug mode to CPU, interrupt
    output var  logic        debug_mode_bit,
    output var  logic        irq
);
    //////////////////////////////////////////////////////////////////////
    // Synchronised pins
    // Pins are levels from another domain, so each passes two flops
    // before any decode reads it
    logic [2:0] pins_s;        // {option, breakpoint, halt}
    // One synchroniser vector serves all three pins
    dbgst_sync u_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in ({read_protect_option, breakpoint_instruction, halt_state}),
        .sync_out (pins_s)
    );
    logic halt_s;              // Halt low-power level
    logic bp_s;                // Breakpoint level, one rise per hit
    logic rprot;               // Protection active
    // Split the synchronised vector back into named levels
    assign halt_s = pins_s[0];
    assign bp_s   = pins_s[1];
    assign rprot  = ~pins_s[2]; // Option programmed to 0 means protected

    //////////////////////////////////////////////////////////////////////
    // State
    // Everything resets to zero; the status image needs three edges
    // after reset before it follows the pins
    dbgst_pkg::dbgst_phase_t ph_r, ph_nxt;     // APB phase
    logic [7:0]              ctrl_r, ctrl_nxt; // Debug control register
    logic                    hit_seen_r, hit_seen_nxt; // Sticky breakpoint
    logic [7:0]              stat_r, stat_nxt; // Registered status image
    dbgst_pkg::dbgst_irq_t   ist_r, ist_nxt;   // Sticky event bits
    dbgst_pkg::dbgst_irq_t   msk_r, msk_nxt;   // Event mask
    logic                    bp_d_r, bp_d_nxt; // Edge detect on breakpoint
    logic                    halt_d_r, halt_d_nxt; // Edge detect on halt
    // Next values of the registered outputs
    logic [31:0]             prdata_nxt;
    logic                    pready_nxt;
    logic                    pslverr_nxt;
    logic                    dbg_nxt;
    logic                    irq_nxt;

    // Decode helpers, all combinational
    logic       acc;      // Access phase completing
    logic       wr;       // Write completing
    logic       ctrl_wr;  // Control write completing
    logic       known;    // Address is mapped
    logic [2:0] ev;       // Events this cycle
    logic       idle;     // Idle flag next value
    logic [7:0] stat_now; // Status image being built

    //////////////////////////////////////////////////////////////////////
    // Next-value logic
    always_comb begin
        // Transfer qualifiers; a write lands only at the access edge
        acc      = psel && penable && (ph_r == dbgst_pkg::DBGST_ACC_PH);
        wr       = acc && pwrite;
        ctrl_wr  = wr && (paddr == `DBGST_OFS_CTRL);
        // Address decode: only the four word offsets are mapped
        if (paddr == `DBGST_OFS_CTRL) begin
            known = 1'b1;
        end else if (paddr == `DBGST_OFS_STATUS) begin
            known = 1'b1;
        end else if (paddr == `DBGST_OFS_IRQ_ST) begin
            known = 1'b1;
        end else if (paddr == `DBGST_OFS_IRQ_MSK) begin
            known = 1'b1;
        end else begin
            known = 1'b0;                       // Refused with an error
        end
        // Phase: setup then single-cycle access
        // A setup held for two cycles would answer twice; masters that
        // keep the bus rules never do that, so no guard is spent on it
        if (psel && !penable) begin
            ph_nxt = dbgst_pkg::DBGST_ACC_PH;   // Setup seen
        end else begin
            ph_nxt = dbgst_pkg::DBGST_IDLE_PH;
        end
        // Control register write; other bits are stored for read-back only
        ctrl_nxt = ctrl_r;
        if (ctrl_wr) begin
            ctrl_nxt = pwdata[7:0];
            // Protected: debug mode bit not writable to 0
            if (rprot && ctrl_r[`DBGST_BIT_MODE]) begin
                ctrl_nxt[`DBGST_BIT_MODE] = 1'b1;
            end
        end
        // The CPU sees the mode bit from the edge that writes it
        dbg_nxt = ctrl_nxt[`DBGST_BIT_MODE];   // Stop or run CPU
        // Breakpoint since last control write; any control write clears
        // it, whatever the data, but a new hit wins over that clear
        bp_d_nxt   = bp_s;
        halt_d_nxt = halt_s;
        if (bp_s && !bp_d_r) begin
            hit_seen_nxt = 1'b1;
        end else if (ctrl_wr) begin
            hit_seen_nxt = 1'b0;                // Cleared by control write
        end else begin
            hit_seen_nxt = hit_seen_r;          // Hold
        end
        idle = dbg_nxt || hit_seen_nxt;
        // Status image, rebuilt every cycle from synchronised levels
        stat_now = 8'h00;                       // Reserved zero
        stat_now[`DBGST_BIT_IDLE]  = idle;
        stat_now[`DBGST_BIT_HALT]  = halt_s;
        stat_now[`DBGST_BIT_RPROT] = rprot;
        stat_nxt = stat_now;                    // No write path
        // Interrupt events: idle rise, halt entry, breakpoint edge
        // Edges only, so a level held high raises each bit once
        ev[0] = idle && !stat_r[`DBGST_BIT_IDLE];
        ev[1] = halt_s && !halt_d_r;
        ev[2] = bp_s && !bp_d_r;
        // Write one to clear; an event in the same cycle survives
        ist_nxt = ist_r;
        if (wr && (paddr == `DBGST_OFS_IRQ_ST)) begin
            ist_nxt = ist_r & ~pwdata[2:0];
        end
        ist_nxt = ist_nxt | ev;                 // Set beats clear
        // Mask is a plain read/write register
        msk_nxt = msk_r;
        if (wr && (paddr == `DBGST_OFS_IRQ_MSK)) begin
            msk_nxt = pwdata[2:0];
        end
        // Level output from next values, so it follows without lag
        irq_nxt = |(ist_nxt & msk_nxt);
        // Read data, valid with pready in the access cycle; taken from
        // registered state at the setup edge, so there is no wait state
        prdata_nxt  = 32'h0000_0000;
        pready_nxt  = psel && !penable;
        pslverr_nxt = psel && !penable && !known;
        // Only reads put data on the bus
        if (psel && !penable && !pwrite) begin
            if (paddr == `DBGST_OFS_CTRL) begin
                prdata_nxt[7:0] = ctrl_r;
            end else if (paddr == `DBGST_OFS_STATUS) begin
                prdata_nxt[7:0] = stat_r;
            end else if (paddr == `DBGST_OFS_IRQ_ST) begin
                prdata_nxt[2:0] = ist_r;
            end else if (paddr == `DBGST_OFS_IRQ_MSK) begin
                prdata_nxt[2:0] = msk_r;
            end else begin
                prdata_nxt = 32'h0000_0000;     // Unmapped reads zero
            end
        end
    end

    //////////////////////////////////////////////////////////////////////
    // Registers
    // Registers only; every top-level output comes from here
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            // All state and outputs to idle values
            ph_r           <= dbgst_pkg::DBGST_IDLE_PH;
            ctrl_r         <= `DBGST_CTRL_RST;
            hit_seen_r     <= 1'b0;
            stat_r         <= 8'h00;
            ist_r          <= `DBGST_MSK_RST;
            msk_r          <= `DBGST_MSK_RST;
            bp_d_r         <= 1'b0;
            halt_d_r       <= 1'b0;
            prdata         <= 32'h0000_0000;
            pready         <= 1'b0;
            pslverr        <= 1'b0;
            debug_mode_bit <= 1'b0;
            irq            <= 1'b0;
        end else begin
            // Take the next values
            ph_r           <= ph_nxt;
            ctrl_r         <= ctrl_nxt;
            hit_seen_r     <= hit_seen_nxt;
            stat_r         <= stat_nxt;
            ist_r          <= ist_nxt;
            msk_r          <= msk_nxt;
            bp_d_r         <= bp_d_nxt;
            halt_d_r       <= halt_d_nxt;
            prdata         <= prdata_nxt;
            pready         <= pready_nxt;
            pslverr        <= pslverr_nxt;
            debug_mode_bit <= dbg_nxt;
            irq            <= irq_nxt;
        end
    end
endmodule
`default_nettype wire

/* File: tb/dbgst_assertions.sv */
/* Port checker for dbgst_top.
   Assumes status pins stay put for several cycles between changes. */
`timescale 1ns/1ps
`default_nettype none
module dbgst_chk (
    // Clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // APB
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Pins
    input wire logic        halt_state,
    input wire logic        breakpoint_instruction,
    input wire logic        read_protect_option,
    input wire logic        debug_mode_bit,
    input wire logic        irq
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Completed control write and status read
    sequence wr_ctl; pready && pwrite && paddr == 12'h000; endsequence
    sequence rd_st; pready && !pwrite && paddr == 12'h004; endsequence
    a_ready_next: assert property (psel && !penable |=> pready ##1 !pready)
        else $error("ready not a one-cycle answer");
    a_bad_addr: assert property (pready && paddr > 12'h00C |-> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    a_idle_mode: assert property (
        rd_st ##0 debug_mode_bit && $past(debug_mode_bit, 4) |-> prdata[7])
        else $error("idle clear in debug mode");
    a_halt_flag: assert property (
        rd_st ##0 $past(halt_state, 5) == halt_state |-> prdata[6] == halt_state)
        else $error("halt flag wrong");
    a_rprot_flag: assert property (
        rd_st ##0 $past(read_protect_option, 5) == read_protect_option
        |-> prdata[5] == !read_protect_option)
        else $error("read-protect flag wrong");
    a_rsvd_zero: assert property (
        rd_st |-> prdata[4:0] == 5'h00 && prdata[31:8] == 24'h0)
        else $error("reserved bits not zero");
    a_mode_set: assert property (wr_ctl ##0 pwdata[7] |=> debug_mode_bit)
        else $error("debug mode not entered");
    a_mode_clear: assert property (
        wr_ctl ##0 !pwdata[7] && read_protect_option
        && $past(read_protect_option, 4) |=> !debug_mode_bit)
        else $error("debug mode not left");
    a_mode_held: assert property (
        wr_ctl ##0 debug_mode_bit && !read_protect_option
        && !$past(read_protect_option, 4) |=> debug_mode_bit)
        else $error("protected debug mode cleared");
endmodule
bind dbgst_top dbgst_chk dbgst_chk_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .halt_state(halt_state),
    .breakpoint_instruction(breakpoint_instruction),
    .read_protect_option(read_protect_option), .debug_mode_bit(debug_mode_bit), .irq(irq));
`default_nettype wire

/* File: tb/dbgst_cpu_model.sv */
/* CPU-side pin model: halt level, breakpoint hits, option bit.
   Assumes the bench calls its tasks from one process. */
`timescale 1ns/1ps
`default_nettype none
module dbgst_cpu_model (
    // Clock
    input  wire logic pclk,
    // Pins toward the block
    output var  logic halt_state,
    output var  logic breakpoint_instruction,
    output var  logic read_protect_option
);
    // Running, unprotected at start
    initial begin
        halt_state = 1'b0;
        breakpoint_instruction = 1'b0;
        read_protect_option = 1'b1;
    end
    // Levels change just after an edge
    task automatic set_pins(input logic h, input logic p);
        @(posedge pclk);
        halt_state <= h;
        read_protect_option <= p;
    endtask
    // Held four edges so the synchroniser cannot miss it
    task automatic hit();
        @(posedge pclk);
        breakpoint_instruction <= 1'b1;
        repeat (4) @(posedge pclk);
        breakpoint_instruction <= 1'b0;
    endtask
endmodule
`default_nettype wire

/* File: tb/test_debug_status_register.sv */
/* Self-checking bench for dbgst_top against an integer model.
   Assumes the CPU model drives the status pins. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, x) begin total_checks++; if ((g) !== (x)) begin n_mismatch++; \
    $display("BAD t=%0t got=%h exp=%h", $time, g, x); end end
module test_debug_status_register;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic        pready, pslverr, e, dbm, irq, hs, bp, rpo;
    int          n_mismatch = 0, total_checks = 0;
    int          mode_m = 0, hit_m = 0, ist_m = 0, rp_m = 1, halt_m = 0;
    always #5 pclk = ~pclk;
    dbgst_top dbgst_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .halt_state(hs), .breakpoint_instruction(bp),
        .read_protect_option(rpo), .debug_mode_bit(dbm), .irq(irq));
    dbgst_cpu_model dbgst_cpu_model_i (.pclk(pclk), .halt_state(hs),
        .breakpoint_instruction(bp), .read_protect_option(rpo));
    task automatic give_verdict();
        $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // One APB transfer, held until pready
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin n_mismatch++; give_verdict(); end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Control write; the model keeps protection stickiness
    task automatic wctl(input logic [7:0] d);
        if (!(mode_m | hit_m) && d[7]) ist_m |= 1;
        apb(1'b1, 12'h000, {24'h0, d});
        mode_m = rp_m ? d[7] : (mode_m | d[7]);
        hit_m = 0;
    endtask
    // Settled status read
    task automatic rs();
        repeat (3) @(posedge pclk);
        apb(1'b0, 12'h004, 32'h0);
    endtask
    function automatic logic [32:0] st_exp();
        return {1'(mode_m), 24'h0, 1'(mode_m | hit_m), 1'(halt_m), 1'(!rp_m), 5'h00};
    endfunction
    initial begin
        void'($urandom(32'h8FDD));
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        rs();
        `CHK({dbm, q}, st_exp())
        apb(1'b1, 12'h004, $urandom & 32'hFFFFFFE0);
        rs();
        `CHK({dbm, q}, st_exp())
        apb(1'b0, 12'h010, 32'h0);
        `CHK({e, q}, {1'b1, 32'h0})
        dbgst_cpu_model_i.set_pins(1'b1, 1'b1);
        halt_m = 1;
        rs();
        `CHK({dbm, q}, st_exp())
        dbgst_cpu_model_i.set_pins(1'b0, 1'b1);
        halt_m = 0;
        wctl(8'h80);
        rs();
        `CHK({dbm, q}, st_exp())
        apb(1'b0, 12'h000, 32'h0);
        `CHK(q, 32'h0000_0080)
        wctl(8'h00);
        rs();
        `CHK({dbm, q}, st_exp())
        apb(1'b1, 12'h008, 32'h7);
        apb(1'b1, 12'h00C, 32'h7);
        apb(1'b0, 12'h00C, 32'h0);
        `CHK(q, 32'h0000_0007)
        ist_m = (mode_m | hit_m) ? 4 : 5;
        dbgst_cpu_model_i.hit();
        hit_m = 1;
        rs();
        `CHK({dbm, q}, st_exp())
        apb(1'b0, 12'h008, 32'h0);
        `CHK({irq, q}, {1'b1, 32'(ist_m)})
        apb(1'b1, 12'h00C, 32'h0);
        repeat (2) @(posedge pclk);
        `CHK(irq, 1'b0)
        apb(1'b1, 12'h00C, 32'h7);
        apb(1'b1, 12'h008, 32'h7);
        repeat (2) @(posedge pclk);
        `CHK(irq, 1'b0)
        wctl(8'h00);
        rs();
        `CHK({dbm, q}, st_exp())
        dbgst_cpu_model_i.set_pins(1'b0, 1'b0);
        rp_m = 0;
        wctl(8'h80);
        wctl(8'h00);
        rs();
        `CHK({dbm, q}, st_exp())
        apb(1'b0, 12'h000, 32'h0);
        `CHK(q, 32'h0000_0080)
        give_verdict();
    end
endmodule
`default_nettype wire
